/* File: verilog/byte_rotate_unit.sv */
// Top of the byte rotate unit: sequences one memory read per command, with a writeback only for memory-destination rotates.
// Assumes a synchronous data memory with one cycle read latency on mclk.
`timescale 1ns/1ps
module byte_rotate_unit (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                reqValid,
    input  bru_pkg::bru_req_type     req,
    output logic                     busy,
    output logic                     done,
    output logic                     memRead,
    output logic                     memWrite,
    output logic [7:0]               memAddr,
    output logic [7:0]               memWdata,
    input  wire logic [7:0]          memRdata,
    output logic [7:0]               acc,
    output logic                     carry
);
    import bru_pkg::*;

    bru_state_type state_reg;
    bru_op_type    op_reg;
    logic [7:0]    rotResult;
    logic          rotCarry;
    logic          rotToMem;

    // Rotation arithmetic on the byte returned by memory.
    bru_rotator uRot (
        .operation (op_reg),
        .operand   (memRdata),
        .carryIn   (carry),
        .result    (rotResult),
        .carryOut  (rotCarry),
        .toMemory  (rotToMem)
    );

    // Sequencer: idle, issue read, take data, then finish.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg    <= OP_ROTATE_LEFT_MEM;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (reqValid) begin
                        state_reg <= ST_READ;
                        op_reg    <= req.op;
                    end
                end
                ST_READ:  state_reg <= ST_WAIT;
                ST_WAIT:  state_reg <= ST_WRITE; // [RQ6]
                ST_WRITE: state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // Memory port: address latched at acceptance, one read then optional write.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            memAddr  <= ADDR_RESET;
            memRead  <= 1'b0;
            memWrite <= 1'b0;
            memWdata <= WDATA_RESET;
        end else begin
            memRead  <= (state_reg == ST_IDLE) && reqValid; // [RQ6]
            memWrite <= (state_reg == ST_WAIT) && rotToMem; // [RQ1] [RQ3] [RQ5]
            if ((state_reg == ST_IDLE) && reqValid) begin
                memAddr <= req.addr;
            end
            if (state_reg == ST_WAIT) begin
                memWdata <= rotResult;
            end
        end
    end

    // Accumulator and carry; memory-destination rotates leave acc alone.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc   <= ACC_RESET;
            carry <= CARRY_RESET;
        end else if (state_reg == ST_WAIT) begin
            if (!rotToMem) begin
                acc <= rotResult; // [RQ2] [RQ4]
            end
            carry <= rotCarry; // [RQ3] [RQ4]
        end
    end

    // Status: busy while sequencing, done pulses with the final cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= ((state_reg == ST_IDLE) && reqValid) || (state_reg == ST_READ) || (state_reg == ST_WAIT);
            done <= (state_reg == ST_WAIT); // [RQ6]
        end
    end
endmodule // byte_rotate_unit

/* File: verilog/bru_pkg.sv */
// Constants and carrier types for the byte rotate unit.
// Assumes a core decoder issuing one rotate command at a time.
// Overview of operation
// RQ1 - Memory left rotate, writeback, flags untouched.
// RQ2 - Left rotate into accumulator, memory kept.
// RQ3 - Nine-bit left rotate through carry, writeback.
// RQ4 - Carry left rotate into accumulator, carry updated.
// RQ5 - Memory right rotate, writeback, flags untouched.
// RQ6 - One read-modify-write; results visible next instruction.
package bru_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic       CARRY_RESET = 1'b0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] WDATA_RESET = 8'h00;

    // Rotate commands from the decoder.
    typedef enum logic [2:0] {
        OP_ROTATE_LEFT_MEM                   = 3'h0,
        OP_ROTATE_LEFT_INTO_ACCUMULATOR      = 3'h1,
        OP_ROTATE_LEFT_CARRY_MEM             = 3'h2,
        OP_ROTATE_LEFT_CARRY_INTO_ACCUMULATOR = 3'h3,
        OP_ROTATE_RIGHT_MEM                  = 3'h4
    } bru_op_type;

    // Request from the decoder.
    typedef struct packed {
        bru_op_type        op;
        logic [ADDR_W-1:0] addr;
    } bru_req_type;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_WRITE = 4'b1000
    } bru_state_type;
endpackage

/* File: verilog/bru_rotator.sv */
// Combinational single-position rotator for the byte rotate unit.
// Assumes operand and carry are stable while the result is used.
`timescale 1ns/1ps
module bru_rotator (
    input  bru_pkg::bru_op_type operation,
    input  wire logic [7:0]     operand,
    input  wire logic           carryIn,
    output logic [7:0]          result,
    output logic                carryOut,
    output logic                toMemory
);
    import bru_pkg::*;

    // Selects the rotation and whether memory or accumulator receives it.
    always_comb begin
        result   = operand;
        carryOut = carryIn;
        toMemory = 1'b0;
        case (operation)
            OP_ROTATE_LEFT_MEM: begin
                result   = {operand[6:0], operand[7]}; // [RQ1]
                toMemory = 1'b1;
            end
            OP_ROTATE_LEFT_INTO_ACCUMULATOR: begin
                result = {operand[6:0], operand[7]}; // [RQ2]
            end
            OP_ROTATE_LEFT_CARRY_MEM: begin
                result   = {operand[6:0], carryIn}; // [RQ3]
                carryOut = operand[7];              // [RQ3]
                toMemory = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY_INTO_ACCUMULATOR: begin
                result   = {operand[6:0], carryIn}; // [RQ4]
                carryOut = operand[7];              // [RQ4]
            end
            OP_ROTATE_RIGHT_MEM: begin
                result   = {operand[0], operand[7:1]}; // [RQ5]
                toMemory = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end
endmodule // bru_rotator

/* File: verif/bru_mem_model.sv */
// Data memory model facing the byte rotate unit.
// Assumes a one-cycle synchronous read on mclk.
`timescale 1ns/1ps
module bru_mem_model (
    input  wire logic       mclk,
    input  wire logic       memRead,
    input  wire logic       memWrite,
    input  wire logic [7:0] memAddr,
    input  wire logic [7:0] memWdata,
    output logic      [7:0] memRdata = 8'h00
);
    logic [7:0] mem [256];
    // Read data is valid one cycle after the strobe, then scrambled.
    always @(posedge mclk) begin
        memRdata <= memRead ? mem[memAddr] : ~memRdata;
        if (memWrite) mem[memAddr] <= memWdata;
    end
endmodule // bru_mem_model

/* File: verif/bru_checker.sv */
// Port assertions for the byte rotate unit.
// Assumes a bind onto byte_rotate_unit.
`timescale 1ns/1ps
module bru_checker (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       reqValid,
    input bru_pkg::bru_req_type req,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       memRead,
    input wire logic       memWrite,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] memWdata,
    input wire logic [7:0] memRdata,
    input wire logic [7:0] acc,
    input wire logic       carry
);
    import bru_pkg::*;
    logic [7:0] rdPrev, accPrev;
    logic       cPrev;
    bru_op_type opReg;
    // Keeps the operand, the old flags and the accepted command.
    always_ff @(posedge mclk) begin
        rdPrev <= memRdata;
        accPrev <= acc;
        cPrev <= carry;
        if (reqValid && !busy && !done) opReg <= req.op;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence accepted; reqValid && !busy && !done; endsequence
    sequence finish; memRead ##2 done; endsequence
    // Busy rises the cycle after acceptance and holds through the done cycle, then drops.
    sequence busySpan; busy [*3] ##1 !busy; endsequence
    property outcome(bru_op_type o, logic w, logic [8:0] e);
        done && opReg == o |-> memWrite == w && {carry, w ? memWdata : acc} == e && (!w || acc == accPrev);
    endproperty
    AST_SEQ: assert property (accepted |=> finish) else $error("rotate timing");
    AST_BUSY: assert property (accepted |=> busySpan) else $error("busy span");
    AST_ADDR: assert property (accepted |=> memAddr == $past(req.addr)) else $error("address not held");
    AST_ROL: assert property (outcome(OP_ROTATE_LEFT_MEM, 1'b1, {cPrev, rdPrev[6:0], rdPrev[7]}))
        else $error("rol");
    AST_ROLA: assert property (outcome(OP_ROTATE_LEFT_INTO_ACCUMULATOR, 1'b0, {cPrev, rdPrev[6:0], rdPrev[7]}))
        else $error("rola");
    AST_RLC: assert property (outcome(OP_ROTATE_LEFT_CARRY_MEM, 1'b1, {rdPrev, cPrev})) else $error("rlc");
    AST_RLCA: assert property (outcome(OP_ROTATE_LEFT_CARRY_INTO_ACCUMULATOR, 1'b0, {rdPrev, cPrev}))
        else $error("rlca");
    AST_RR: assert property (outcome(OP_ROTATE_RIGHT_MEM, 1'b1, {cPrev, rdPrev[0], rdPrev[7:1]}))
        else $error("rr");
endmodule // bru_checker
bind byte_rotate_unit bru_checker chk (.*);

/* File: verif/test_byte_rotate_unit.sv */
// Self-checking bench for the byte rotate unit.
// Assumes the memory model answers every read strobe.
`timescale 1ns/1ps
module test_byte_rotate_unit;
    import bru_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, busy, done, memRead, memWrite, carry, expC;
    logic [7:0]  memAddr, memWdata, memRdata, acc, expAcc;
    bru_req_type req = '0;
    int          mismatches, checked;
    always #20 mclk = ~mclk;
    byte_rotate_unit dut (.*);
    bru_mem_model mdl (.*);
    // Ends the run with the verdict.
    task automatic results();
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Compares a seen value with its expectation.
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Runs one rotation; with hold set a second request is offered while busy.
    task automatic doOp(input bru_op_type op, input logic [7:0] a, input logic [7:0] d, input logic hold);
        logic [8:0] r;
        mdl.mem[a] = d;
        mdl.mem[a ^ 8'h01] = ~d;
        r = op[2] ? {expC, d[0], d[7:1]} : op[1] ? {d, expC} : {expC, d[6:0], d[7]};
        @(posedge mclk);
        reqValid <= 1'b1;
        req <= '{op, a};
        @(posedge mclk);
        reqValid <= hold;
        req.addr <= a ^ 8'h01;
        @(posedge mclk);
        reqValid <= 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) @(posedge mclk) #1;
        check({8'h00, done}, 9'h001);
        if (done !== 1'b1) results();
        expC = r[8];
        if (op[0]) expAcc = r[7:0];
        check({carry, acc}, {expC, expAcc});
        @(posedge mclk) #1;
        check({1'b0, mdl.mem[a]}, {1'b0, op[0] ? d : r[7:0]});
        check({1'b0, mdl.mem[a ^ 8'h01]}, {1'b0, ~d});
        check({6'h00, busy, done, memWrite}, 9'h000);
    endtask
    // Outputs while reset is still applied.
    task automatic resetValues();
        check({1'b0, memAddr}, {1'b0, ADDR_RESET});
        check({1'b0, memWdata}, {1'b0, WDATA_RESET});
        check({carry, acc}, {CARRY_RESET, ACC_RESET});
        check({5'h00, busy, done, memRead, memWrite}, 9'h000);
    endtask
    // Left rotations with carry clear and set.
    task automatic leftRotates();
        doOp(OP_ROTATE_LEFT_MEM, 8'h10, 8'h81, 1'b0);
        doOp(OP_ROTATE_LEFT_CARRY_MEM, 8'h20, 8'h80, 1'b0);
        doOp(OP_ROTATE_LEFT_CARRY_INTO_ACCUMULATOR, 8'h30, 8'hc0, 1'b0);
        doOp(OP_ROTATE_LEFT_INTO_ACCUMULATOR, 8'h40, 8'h40, 1'b0);
    endtask
    // Right rotation while a second request is refused.
    task automatic rightRefused();
        doOp(OP_ROTATE_RIGHT_MEM, 8'h50, 8'h01, 1'b1);
    endtask
    // Reset, scenarios, verdict.
    initial begin
        expC = CARRY_RESET;
        expAcc = ACC_RESET;
        repeat (6) @(posedge mclk);
        resetValues();
        rst_n <= 1'b1;
        leftRotates();
        rightRefused();
        results();
    end
endmodule // test_byte_rotate_unit
